//--- ext_bus_pkg.sv
package ext_bus_pkg;

    // Oscillator and machine cycle framing
    localparam int          CLK_HZ          = 50_000_000;
    localparam int          OSC_PER_MCYCLE  = 12;
    localparam logic [3:0]  LAST_PHASE      = 4'(OSC_PER_MCYCLE - 1);
    localparam int          RESET_MCYCLES   = 2;
    localparam logic [4:0]  RESET_QUAL      = 5'(RESET_MCYCLES * OSC_PER_MCYCLE);

    // Strobe placement within a machine cycle, in oscillator phases
    localparam logic [3:0]  ALE_A_START     = 4'h1;
    localparam logic [3:0]  ALE_A_END       = 4'h2;
    localparam logic [3:0]  ALE_B_START     = 4'h7;
    localparam logic [3:0]  ALE_B_END       = 4'h8;
    localparam logic [3:0]  FETCH_A_START   = 4'h3;
    localparam logic [3:0]  FETCH_A_END     = 4'h5;
    localparam logic [3:0]  FETCH_B_START   = 4'h9;
    localparam logic [3:0]  FETCH_B_END     = 4'hB;
    localparam logic [3:0]  DSTB_START      = 4'h1;
    localparam logic [3:0]  DSTB_END        = 4'h9;

    // Address space and port 3 layout
    localparam logic [15:0] INTERNAL_TOP    = 16'h0FFF;
    localparam int          P3_WRITE_BIT    = 6;
    localparam int          P3_READ_BIT     = 7;
    localparam logic [7:0]  P3_RESET        = 8'hFF;

    // Data move request from the core, offered for the next machine cycle
    typedef struct packed {
        logic valid;
        logic write;
    } data_move_t;

    // Machine cycle kinds
    typedef enum logic [1:0] {
        CYC_NORMAL    = 2'b00,
        CYC_MOVE_ADDR = 2'b01,
        CYC_MOVE_DATA = 2'b10
    } cycle_kind_t;

endpackage

//--- ext_memory_bus_strobes.sv
`timescale 1ns/1ns
module ext_memory_bus_strobes (
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_reset_pin,
    input  wire logic                    i_external_fetch_select,
    input  wire logic                    i_ale_inhibit,
    input  wire logic [15:0]             i_fetch_addr,
    input  wire ext_bus_pkg::data_move_t i_data_move,
    input  wire logic [7:0]              i_port3_latch,
    input  wire logic [7:0]              i_port3_pin,
    output logic                         o_core_reset,
    output logic                         o_mcycle_start,
    output logic [3:0]                   o_phase,
    output logic                         o_address_latch_strobe,
    output logic                         o_program_fetch_strobe_n,
    output logic [7:0]                   o_port3_out,
    output logic [7:0]                   o_port3_oe,
    output logic [7:0]                   o_port3_pullup,
    output logic [7:0]                   o_port3_in
);
    import ext_bus_pkg::*;

    // Returns true when phase p lies within [a, b]
    function automatic logic in_window(input logic [3:0] p,
                                       input logic [3:0] a,
                                       input logic [3:0] b);
        in_window = (p >= a) && (p <= b);
    endfunction

    // Reset pin qualifier state
    logic [4:0]  rst_count;
    logic [4:0]  next_rst_count;
    logic        core_reset;
    logic        next_core_reset;

    // Sequencer state, all but the phase count fixed at machine cycle boundaries
    logic [3:0]  phase;
    logic [3:0]  next_phase;
    cycle_kind_t kind;
    cycle_kind_t next_kind;
    logic        move_write;
    logic        next_move_write;
    logic        fetch_ext;
    logic        next_fetch_ext;
    logic        ale_hold;
    logic        next_ale_hold;

    // Strobe and port 3 state; read and write requests are decoded only
    logic        ale;
    logic        next_ale;
    logic        fetch_n;
    logic        next_fetch_n;
    logic        rd_n;
    logic        wr_n;
    logic        mstart;
    logic        next_mstart;
    logic [7:0]  p3_out;
    logic [7:0]  next_p3_out;
    logic [7:0]  p3_oe;
    logic [7:0]  next_p3_oe;
    logic [7:0]  p3_pu;
    logic [7:0]  next_p3_pu;
    logic [7:0]  p3_in;

    // Reset pin qualifier; a short glitch on the pin never resets the core
    always_comb begin
        next_rst_count  = rst_count;
        next_core_reset = core_reset;
        if (!i_reset_pin) begin
            next_rst_count  = '0;
            next_core_reset = 1'b0;
        // Count saturates one short; the next high sample sets reset
        end else if (rst_count == RESET_QUAL - 5'h01) begin
            next_core_reset = 1'b1;
        end else begin
            next_rst_count  = rst_count + 5'h01;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rst_count  <= 5'h00;
            core_reset <= 1'b1;
        end else begin
            rst_count  <= next_rst_count;
            core_reset <= next_core_reset;
        end
    end

    // Machine cycle sequencer; kind and fetch source fixed at each boundary
    always_comb begin
        next_phase      = phase;
        next_kind       = kind;
        next_move_write = move_write;
        next_fetch_ext  = fetch_ext;
        next_ale_hold   = ale_hold;
        next_mstart     = 1'b0;
        if (core_reset) begin
            // Park on the last phase so the first cycle opens cleanly
            next_phase     = LAST_PHASE;
            next_kind      = CYC_NORMAL;
            next_fetch_ext = 1'b0;
        end else if (phase == LAST_PHASE) begin
            next_phase  = 4'h0;
            next_mstart = 1'b1;
            // Internal code space only when select is high and at or below the top
            next_fetch_ext = !i_external_fetch_select
                             || (i_fetch_addr > INTERNAL_TOP);
            // Inhibit taken only here, so a latch pulse is never cut short
            next_ale_hold  = i_ale_inhibit;
            case (kind)
                CYC_NORMAL: begin
                    if (i_data_move.valid) begin
                        next_kind       = CYC_MOVE_ADDR;
                        next_move_write = i_data_move.write;
                    end
                end
                CYC_MOVE_ADDR: begin
                    next_kind = CYC_MOVE_DATA;
                end
                CYC_MOVE_DATA: begin
                    next_kind = CYC_NORMAL;
                end
                default: begin
                    next_kind = CYC_NORMAL;
                end
            endcase
        end else begin
            next_phase = phase + 4'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            phase      <= LAST_PHASE;
            kind       <= CYC_NORMAL;
            move_write <= 1'b0;
            fetch_ext  <= 1'b0;
            ale_hold   <= 1'b0;
            mstart     <= 1'b0;
        end else begin
            phase      <= next_phase;
            kind       <= next_kind;
            move_write <= next_move_write;
            fetch_ext  <= next_fetch_ext;
            ale_hold   <= next_ale_hold;
            mstart     <= next_mstart;
        end
    end

    // Strobe shaping, registered so every pin comes from a flip-flop
    always_comb begin
        logic ale_a;
        logic ale_b;
        logic ale_ok;
        logic fetch_win;
        logic dstb_win;
        ale_a     = in_window(phase, ALE_A_START, ALE_A_END);
        ale_b     = in_window(phase, ALE_B_START, ALE_B_END);
        fetch_win = in_window(phase, FETCH_A_START, FETCH_A_END)
                    || in_window(phase, FETCH_B_START, FETCH_B_END);
        dstb_win  = in_window(phase, DSTB_START, DSTB_END);
        // With inhibit set, latch pulses appear only inside a data move
        ale_ok    = !ale_hold || (kind != CYC_NORMAL);
        // Idle levels; all strobes rest here under core reset
        next_ale     = 1'b0;
        next_fetch_n = 1'b1;
        rd_n         = 1'b1;
        wr_n         = 1'b1;
        if (!core_reset) begin
            // Data cycle: first latch pulse and both fetch pulses give way
            if (kind == CYC_MOVE_DATA) begin
                next_ale = ale_b && ale_ok;
                rd_n     = !(dstb_win && !move_write);
                wr_n     = !(dstb_win && move_write);
            end else begin
                // Address and normal cycles keep the full pattern
                next_ale     = (ale_a || ale_b) && ale_ok;
                next_fetch_n = !(fetch_win && fetch_ext);
            end
        end
        // Strobes override the latch; a driven pin is pulled low only
        next_p3_out              = 8'h00;
        next_p3_oe               = ~i_port3_latch;
        next_p3_oe[P3_WRITE_BIT] = !i_port3_latch[P3_WRITE_BIT] || !wr_n;
        next_p3_oe[P3_READ_BIT]  = !i_port3_latch[P3_READ_BIT] || !rd_n;
        // Weak pull-up where the latch holds a one and no strobe drives
        next_p3_pu = i_port3_latch & ~next_p3_oe;
    end

    // Pins released and pulled high after reset
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ale     <= 1'b0;
            fetch_n <= 1'b1;
            p3_out <= 8'h00;
            p3_oe  <= 8'h00;
            p3_pu  <= P3_RESET;
            p3_in  <= 8'hFF;
        end else begin
            ale     <= next_ale;
            fetch_n <= next_fetch_n;
            p3_out <= next_p3_out;
            p3_oe  <= next_p3_oe;
            p3_pu  <= next_p3_pu;
            p3_in  <= i_port3_pin;   // Pins double as inputs when pulled up
        end
    end

    // Outputs straight from flip-flops
    assign o_core_reset             = core_reset;
    assign o_mcycle_start           = mstart;
    assign o_phase                  = phase;
    assign o_address_latch_strobe   = ale;
    assign o_program_fetch_strobe_n = fetch_n;
    assign o_port3_out              = p3_out;
    assign o_port3_oe               = p3_oe;
    assign o_port3_pullup           = p3_pu;
    assign o_port3_in               = p3_in;

endmodule

//--- ext_memory_bus_strobes_properties.sv
`timescale 1ns/1ns
module ext_memory_bus_strobes_properties (
    input wire logic       i_ref_clk,
    input wire logic       i_rst_n,
    input wire logic       o_core_reset,
    input wire logic       o_mcycle_start,
    input wire logic [3:0] o_phase,
    input wire logic       o_address_latch_strobe,
    input wire logic       o_program_fetch_strobe_n,
    input wire logic [7:0] o_port3_oe
);
    logic ale;
    logic pf_n;
    logic dstb;

    // Short aliases; data strobe means either port 3 strobe pin pulled low
    assign ale = o_address_latch_strobe;
    assign pf_n = o_program_fetch_strobe_n;
    assign dstb = |o_port3_oe[7:6];

    // One clock domain only
    default clocking @(posedge i_ref_clk); endclocking
    // Core reset may cut a strobe short, so shape checks pause meanwhile
    default disable iff (!i_rst_n || o_core_reset);

    a_ale_width: assert property ($rose(ale) |=> ale ##1 !ale)
        else $error("latch strobe width");
    a_phase_wrap: assert property (o_phase == 4'hB && !o_core_reset |=> o_phase == 4'h0)
        else $error("phase wrap");
    a_fetch_width: assert property ($fell(pf_n) |=> !pf_n [*2] ##1 pf_n)
        else $error("fetch strobe width");
    a_fetch_phase: assert property (!pf_n |-> $past(o_phase) inside {[4'h3:4'h5], [4'h9:4'hB]})
        else $error("fetch strobe phase");
    a_data_width: assert property ($rose(dstb) |=> dstb [*8] ##1 !dstb)
        else $error("data strobe width");
    a_data_no_fetch: assert property (dstb |-> pf_n)
        else $error("fetch during data");
    a_ale_skipped: assert property ($rose(dstb) |-> !ale [*2])
        else $error("latch strobe not skipped");
    a_reset_idle: assert property (disable iff (!i_rst_n)
        o_core_reset && $past(o_core_reset) |-> !ale && pf_n && !dstb)
        else $error("strobes under reset");
    a_cycle_start: assert property (o_mcycle_start == (o_phase == 4'h0))
        else $error("cycle start off phase zero");
endmodule

bind ext_memory_bus_strobes ext_memory_bus_strobes_properties u_props (
    .i_ref_clk                (i_ref_clk),
    .i_rst_n                  (i_rst_n),
    .o_core_reset             (o_core_reset),
    .o_mcycle_start           (o_mcycle_start),
    .o_phase                  (o_phase),
    .o_address_latch_strobe   (o_address_latch_strobe),
    .o_program_fetch_strobe_n (o_program_fetch_strobe_n),
    .o_port3_oe               (o_port3_oe)
);

//--- ext_mem_partner.sv
`timescale 1ns/1ns
module ext_mem_partner (
    input  wire logic       i_ref_clk,
    input  wire logic       i_ale,
    input  wire logic       i_fetch_n,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_pullup,
    output logic [7:0]      o_pin,
    output int              o_cnt [4]
);
    logic [7:0] drift = 8'h5A;
    logic       ale_q = 1'b0;
    logic       fetch_q = 1'b1;
    logic [7:0] oe_q = 8'h00;

    // Unpulled, undriven pins wander so a stale level never reads as valid
    assign o_pin = (i_oe & i_out) | (~i_oe & (i_pullup | drift));

    // Latch and memories see strobe edges: latch, fetch, write, read
    always @(posedge i_ref_clk) begin
        drift <= ~drift;
        ale_q <= i_ale;
        fetch_q <= i_fetch_n;
        oe_q <= i_oe;
        o_cnt[0] <= o_cnt[0] + int'(i_ale && !ale_q);
        o_cnt[1] <= o_cnt[1] + int'(fetch_q && !i_fetch_n);
        o_cnt[2] <= o_cnt[2] + int'(i_oe[6] && !oe_q[6]);
        o_cnt[3] <= o_cnt[3] + int'(i_oe[7] && !oe_q[7]);
    end
endmodule

//--- ext_memory_bus_strobes_tb.sv
`timescale 1ns/1ns
module ext_memory_bus_strobes_tb;
    import ext_bus_pkg::*;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
    logic        i_ref_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_reset_pin = 1'b1;
    logic        i_external_fetch_select = 1'b0;
    logic        i_ale_inhibit = 1'b0;
    logic [15:0] i_fetch_addr = 16'h0000;
    data_move_t  i_data_move = '0;
    logic [7:0]  i_port3_latch = 8'hFF;
    logic [7:0]  i_port3_pin;
    logic        o_core_reset, o_mcycle_start, o_address_latch_strobe, o_program_fetch_strobe_n;
    logic [3:0]  o_phase;
    logic [7:0]  o_port3_out, o_port3_oe, o_port3_pullup, o_port3_in;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cnt [4];
    int          d [4];

    ext_memory_bus_strobes DUT (
        .i_ref_clk                (i_ref_clk),
        .i_rst_n                  (i_rst_n),
        .i_reset_pin              (i_reset_pin),
        .i_external_fetch_select  (i_external_fetch_select),
        .i_ale_inhibit            (i_ale_inhibit),
        .i_fetch_addr             (i_fetch_addr),
        .i_data_move              (i_data_move),
        .i_port3_latch            (i_port3_latch),
        .i_port3_pin              (i_port3_pin),
        .o_core_reset             (o_core_reset),
        .o_mcycle_start           (o_mcycle_start),
        .o_phase                  (o_phase),
        .o_address_latch_strobe   (o_address_latch_strobe),
        .o_program_fetch_strobe_n (o_program_fetch_strobe_n),
        .o_port3_out              (o_port3_out),
        .o_port3_oe               (o_port3_oe),
        .o_port3_pullup           (o_port3_pullup),
        .o_port3_in               (o_port3_in)
    );
    ext_mem_partner mem (.i_ref_clk(i_ref_clk), .i_ale(o_address_latch_strobe),
        .i_fetch_n(o_program_fetch_strobe_n), .i_oe(o_port3_oe), .i_out(o_port3_out),
        .i_pullup(o_port3_pullup), .o_pin(i_port3_pin), .o_cnt(cnt));

    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    // Land on phase 0 after at least one full machine cycle
    task automatic align();
        repeat (12) @(negedge i_ref_clk);
        for (int k = 0; k < 12 && o_phase !== 4'h0; k++) @(negedge i_ref_clk);
    endtask

    // Strobe edges over n machine cycles: latch, fetch, write, read
    task automatic window(input int n);
        d = cnt;
        repeat (12 * n) @(negedge i_ref_clk);
        foreach (d[k]) d[k] = cnt[k] - d[k];
    endtask

    task automatic t_reset();
        @(negedge i_ref_clk);
        `CHK("core reset", 1'b1, o_core_reset)
        @(posedge i_ref_clk) i_reset_pin <= 1'b0;
        repeat (4) @(negedge i_ref_clk);
        `CHK("core reset", 1'b0, o_core_reset)
        // One sample short must not reset; a full two machine cycles must
        for (int n = 23; n <= 24; n++) begin
            @(posedge i_ref_clk) i_reset_pin <= 1'b1;
            repeat (n) @(posedge i_ref_clk);
            i_reset_pin <= 1'b0;
            @(negedge i_ref_clk);
            `CHK("qualified reset", n == 24, o_core_reset)
            repeat (4) @(posedge i_ref_clk);
        end
        $display("reset test done");
    endtask

    task automatic t_fetch();
        for (int k = 0; k < 2; k++) begin
            @(posedge i_ref_clk) i_external_fetch_select <= k[0];
            i_fetch_addr <= k ? 16'h0FFF : 16'h1000;
            align();
            `CHK("cycle start", 1'b1, o_mcycle_start)
            window(4);
            `CHK("latch strobes", 8, d[0])
            `CHK("fetch strobes", k ? 0 : 8, d[1])
            `CHK("data strobes", 0, d[2] + d[3])
        end
        @(posedge i_ref_clk) i_external_fetch_select <= 1'b0;
        $display("fetch test done");
    endtask

    task automatic t_move(input logic inh);
        @(posedge i_ref_clk) i_ale_inhibit <= inh;
        for (int w = 0; w < 2; w++) begin
            align();
            for (int k = 0; k < 24 && o_phase !== 4'hA; k++) @(negedge i_ref_clk);
            @(posedge i_ref_clk) i_data_move <= '{valid: 1'b1, write: w[0]};
            @(posedge i_ref_clk) i_data_move <= '0;
            @(negedge i_ref_clk);
            window(3);
            `CHK("latch strobes", inh ? 3 : 5, d[0])
            `CHK("fetch strobes", 4, d[1])
            `CHK("write strobes", w, d[2])
            `CHK("read strobes", 1 - w, d[3])
        end
        window(2);
        `CHK("idle latch strobes", inh ? 0 : 4, d[0])
        @(posedge i_ref_clk) i_ale_inhibit <= 1'b0;
        $display("move test done");
    endtask

    task automatic t_port();
        // Strobe pins keep a one so the data strobe checks stay quiet
        @(posedge i_ref_clk) i_port3_latch <= 8'hCF;
        repeat (3) @(negedge i_ref_clk);
        `CHK("pull-ups", 8'hCF, o_port3_pullup)
        `CHK("drive enables", 8'h30, o_port3_oe)
        `CHK("drive levels", 8'h00, o_port3_out)
        `CHK("pin inputs", 8'hCF, o_port3_in)
        @(posedge i_ref_clk) i_port3_latch <= 8'hFF;
        $display("port test done");
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Whole run is about fifty machine cycles; allow ample margin
    initial begin
        #400000;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_fetch();
        t_move(1'b0);
        t_move(1'b1);
        t_port();
        print_verdict();
    end
endmodule
